// ---- fsr_pkg.sv ----
// package of register map, field layout, reset values and carriers for the fault supervision block
package fsr_pkg;

   // ------------------------------------------------------------------
   // register map (register port offsets)
   // ------------------------------------------------------------------
   localparam logic [7:0]  FSR_OFS_OC_CTRL     = 8'h04;   // overcurrent_fault_control
   localparam logic [7:0]  FSR_OFS_PROTECT     = 8'h05;   // auto_protect_enable
   localparam logic [7:0]  FSR_OFS_STATUS      = 8'h06;   // interrupt_status

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int          FSR_POS_ALLOW_REQ   = 14;      // request-policy bit
   localparam int          FSR_POS_CLEAN_LO    = 5;       // clean_cycles_to_reset [6:5]
   localparam int          FSR_POS_FAULT_LO    = 2;       // overcurrent_fault_threshold [4:2]
   localparam int          FSR_POS_WARN_LO     = 0;       // overcurrent_warning_threshold [1:0]
   localparam int          FSR_FLG_FOREIGN_LO  = 10;      // first of the foreign event flags [14:10]
   localparam int          FSR_FLG_OC_FAULT    = 7;       // overcurrent fault
   localparam int          FSR_FLG_OC_WARN     = 6;       // overcurrent warning
   localparam int          FSR_FLG_PUMP_TMO    = 5;       // charge pump start timeout
   localparam int          FSR_FLG_PUMP_LOSS   = 4;       // charge pump no longer good
   localparam int          FSR_FLG_UNDERVOLT   = 3;       // undervoltage
   localparam int          FSR_FLG_OVERTEMP    = 2;       // temperature no longer good
   localparam int          FSR_FLG_BIAS_FAIL   = 1;       // bias_failure_flag
   localparam int          FSR_FLG_PIN_RISE    = 0;       // enable_pin_rise_flag

   // ------------------------------------------------------------------
   // reset values and writable masks
   // ------------------------------------------------------------------
   localparam logic [15:0] FSR_RST_OC_CTRL     = 16'h0001;
   localparam logic [15:0] FSR_MSK_OC_CTRL     = 16'h407F;
   localparam logic [15:0] FSR_RST_PROTECT     = 16'h001F;
   localparam logic [15:0] FSR_MSK_PROTECT     = 16'h001F;
   localparam logic [15:0] FSR_RST_STATUS      = 16'h0000;
   localparam logic [15:0] FSR_MSK_STATUS      = 16'h7CFF;
   localparam logic [15:0] FSR_FAULT_FLAGS     = 16'h00BF;  // flags that block playback
   localparam logic [2:0]  FSR_FAULT_CODE_OFF  = 3'h7;      // no current-limit protection

   // ------------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic        wr;       // write strobe, one cycle
      logic        rd;       // read strobe, one cycle
      logic [7:0]  addr;     // register offset
      logic [15:0] wdata;    // write data
   } fsr_req_t;

   typedef struct packed {
      logic current_limit_pulse;    // boost current-limit comparator
      logic boost_on_cycle;         // toggles high once per boost on-time
      logic charge_pump_good;
      logic undervoltage;
      logic temperature_good;
      logic bias_good;
      logic enable_pin_active_low;
   } fsr_analog_t;

   // idle levels of the analog conditions: pump, temperature and bias good, pin low
   localparam fsr_analog_t FSR_RST_ANALOG = 7'h16;

endpackage : fsr_pkg

// ---- fsr_core.sv ----
// fault supervision logic: current-limit counting, fault protection and interrupt status
`timescale 1ns/10ps
module fsr_core (
   input  wire logic                core_clk,        // 200 MHz system clock
   input  wire logic                sys_rst,         // asynchronous, active high
   input  wire fsr_pkg::fsr_req_t   reg_req,         // register port request, same clock
   output logic [15:0]              reg_rdata,       // read data, one cycle after rd
   input  wire fsr_pkg::fsr_analog_t analog_in,      // raw conditions from analog front end
   input  wire logic                haptic_active,   // haptic operation in progress
   input  wire logic                pump_start_timeout, // charge pump start timeout event
   input  wire logic [4:0]          other_events,    // foreign event pulses for flags 14..10
   input  wire logic                play_req,        // new playback request
   output logic                     play_accept,     // request taken
   output logic                     play_reject,     // request refused
   output logic                     protect_shutdown // automatic fault protection engaged
);
   import fsr_pkg::*;

   // ------------------------------------------------------------------
   // threshold decoding
   // ------------------------------------------------------------------
   // pulses per warning
   function automatic logic [10:0] fsr_warn_limit(input logic [1:0] code);
      fsr_warn_limit = 11'h080 << code;
   endfunction : fsr_warn_limit

   // warnings per fault
   function automatic logic [8:0] fsr_fault_limit(input logic [2:0] code);
      fsr_fault_limit = 9'h004 << code;
   endfunction : fsr_fault_limit

   // clean on-time cycles per counter reset
   function automatic logic [6:0] fsr_clean_limit(input logic [1:0] code);
      logic [6:0] lim;
      lim = 7'h02;
      unique case (code)
         2'h0: lim = 7'h02;
         2'h1: lim = 7'h08;
         2'h2: lim = 7'h10;
         2'h3: lim = 7'h40;
      endcase
      fsr_clean_limit = lim;
   endfunction : fsr_clean_limit

   // ------------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------------
   fsr_analog_t sync1_ff;            // first stage, read only by second stage
   fsr_analog_t sync2_ff;            // second stage, safe to use
   fsr_analog_t prev_ff;             // previous value for edge detection

   // two flops before any logic looks at the analog levels
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         // idle levels, so no false edge or bias flag follows reset
         sync1_ff <= FSR_RST_ANALOG;
         sync2_ff <= FSR_RST_ANALOG;
         prev_ff  <= FSR_RST_ANALOG;
      end else begin
         sync1_ff <= analog_in;
         sync2_ff <= sync1_ff;
         prev_ff  <= sync2_ff;
      end
   end

   wire pulse_evt = sync2_ff.current_limit_pulse & ~prev_ff.current_limit_pulse; // pulse rising edge
   wire cycle_evt = sync2_ff.boost_on_cycle & ~prev_ff.boost_on_cycle;           // new on-time cycle
   wire pin_rise  = sync2_ff.enable_pin_active_low & ~prev_ff.enable_pin_active_low;

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   logic [15:0] oc_ctrl_ff;          // overcurrent_fault_control
   logic [15:0] protect_en_ff;       // auto_protect_enable
   logic [15:0] status_ff;           // interrupt_status
   logic [15:0] nxt_status;
   logic [15:0] rdata_ff;

   wire sel_ctrl   = reg_req.addr == FSR_OFS_OC_CTRL;
   wire sel_prot   = reg_req.addr == FSR_OFS_PROTECT;
   wire sel_status = reg_req.addr == FSR_OFS_STATUS;

   wire [1:0] clean_code = oc_ctrl_ff[FSR_POS_CLEAN_LO +: 2];
   wire [2:0] fault_code = oc_ctrl_ff[FSR_POS_FAULT_LO +: 3];
   wire [1:0] warn_code  = oc_ctrl_ff[FSR_POS_WARN_LO +: 2];
   wire       allow_req  = oc_ctrl_ff[FSR_POS_ALLOW_REQ];

   // register writes; reserved bits stay zero
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         oc_ctrl_ff    <= FSR_RST_OC_CTRL;
         protect_en_ff <= FSR_RST_PROTECT;
      end else if (reg_req.wr) begin
         if (sel_ctrl) begin
            oc_ctrl_ff <= reg_req.wdata & FSR_MSK_OC_CTRL;
         end
         if (sel_prot) begin
            protect_en_ff <= reg_req.wdata & FSR_MSK_PROTECT;
         end
      end
   end

   // read data is registered; unmapped offsets read zero
   wire [15:0] rd_mux = sel_ctrl   ? oc_ctrl_ff :
                        sel_prot   ? protect_en_ff :
                        sel_status ? status_ff : 16'h0000;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_ff <= 16'h0000;
      end else if (reg_req.rd) begin
         rdata_ff <= rd_mux;
      end
   end
   assign reg_rdata = rdata_ff;

   // ------------------------------------------------------------------
   // current-limit counting
   // ------------------------------------------------------------------
   logic [10:0] pulse_cnt_ff;        // consecutive current-limit pulses
   logic [6:0]  clean_cnt_ff;        // on-time cycles since last pulse
   logic [8:0]  warn_cnt_ff;         // warnings since last fault

   wire warn_hit  = pulse_evt && (pulse_cnt_ff + 11'h001 == fsr_warn_limit(warn_code));
   wire clean_hit = cycle_evt && !pulse_evt
                    && (clean_cnt_ff + 7'h01 == fsr_clean_limit(clean_code));
   wire fault_hit = warn_hit && (fault_code != FSR_FAULT_CODE_OFF)
                    && (warn_cnt_ff + 9'h001 == fsr_fault_limit(fault_code));

   // a pulse restarts the clean run; a clean run or a warning restarts pulse count
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pulse_cnt_ff <= 11'h000;
         clean_cnt_ff <= 7'h00;
         warn_cnt_ff  <= 9'h000;
      end else begin
         if (pulse_evt) begin
            clean_cnt_ff <= 7'h00;
         end else if (clean_hit) begin
            clean_cnt_ff <= 7'h00;
         end else if (cycle_evt) begin
            clean_cnt_ff <= clean_cnt_ff + 7'h01;
         end
         if (warn_hit || clean_hit) begin
            pulse_cnt_ff <= 11'h000;
         end else if (pulse_evt) begin
            pulse_cnt_ff <= pulse_cnt_ff + 11'h001;
         end
         if (fault_hit) begin
            warn_cnt_ff <= 9'h000;
         end else if (warn_hit && fault_code != FSR_FAULT_CODE_OFF) begin
            warn_cnt_ff <= warn_cnt_ff + 9'h001;
         end
      end
   end

   // ------------------------------------------------------------------
   // interrupt status flags
   // ------------------------------------------------------------------
   logic [15:0] set_vec;
   always_comb begin
      set_vec = 16'h0000;
      set_vec[FSR_FLG_FOREIGN_LO +: 5] = other_events;
      set_vec[FSR_FLG_OC_FAULT]        = fault_hit;
      set_vec[FSR_FLG_OC_WARN]         = warn_hit;
      set_vec[FSR_FLG_PUMP_TMO]        = pump_start_timeout;
      set_vec[FSR_FLG_PUMP_LOSS]       = ~sync2_ff.charge_pump_good & prev_ff.charge_pump_good;
      set_vec[FSR_FLG_UNDERVOLT]       = sync2_ff.undervoltage & ~prev_ff.undervoltage;
      set_vec[FSR_FLG_OVERTEMP]        = ~sync2_ff.temperature_good & prev_ff.temperature_good;
      set_vec[FSR_FLG_BIAS_FAIL]       = ~sync2_ff.bias_good;
      set_vec[FSR_FLG_PIN_RISE]        = pin_rise & haptic_active;
   end

   // read clears all; a set in the same cycle still wins
   wire status_read = reg_req.rd && sel_status;
   assign nxt_status = ((status_read ? 16'h0000 : status_ff) | set_vec) & FSR_MSK_STATUS;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         status_ff <= FSR_RST_STATUS;
      end else begin
         status_ff <= nxt_status;
      end
   end

   // ------------------------------------------------------------------
   // automatic protection
   // ------------------------------------------------------------------
   logic protect_ff;
   // the overcurrent fault always and the enabled conditions shut the boost down; held until the flags are read
   wire prot_now = (status_ff[FSR_FLG_OC_FAULT])
                 | (status_ff[FSR_FLG_PUMP_LOSS] & protect_en_ff[4])
                 | (status_ff[FSR_FLG_UNDERVOLT] & protect_en_ff[3])
                 | (status_ff[FSR_FLG_OVERTEMP]  & protect_en_ff[2])
                 | (status_ff[FSR_FLG_BIAS_FAIL] & protect_en_ff[1])
                 | (status_ff[FSR_FLG_PIN_RISE]  & protect_en_ff[0]);

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         protect_ff <= 1'b0;
      end else begin
         protect_ff <= prot_now;
      end
   end
   assign protect_shutdown = protect_ff;

   // ------------------------------------------------------------------
   // playback request policy
   // ------------------------------------------------------------------
   wire fault_pending = |(status_ff & FSR_FAULT_FLAGS);
   assign play_accept = play_req & (allow_req | ~fault_pending);
   assign play_reject = play_req & ~allow_req & fault_pending;

endmodule : fsr_core

// ---- fsr_core_sva.sv ----
// checker of register port answers and playback gating for the fault supervision core
`timescale 1ns/10ps
module fsr_core_chk (
   input wire logic                 core_clk,
   input wire logic                 sys_rst,
   input wire fsr_pkg::fsr_req_t    reg_req,
   input wire logic [15:0]          reg_rdata,
   input wire fsr_pkg::fsr_analog_t analog_in,
   input wire logic                 haptic_active,
   input wire logic                 pump_start_timeout,
   input wire logic [4:0]           other_events,
   input wire logic                 play_req,
   input wire logic                 play_accept,
   input wire logic                 play_reject,
   input wire logic                 protect_shutdown
);
   import fsr_pkg::*;
   // ------------------------------------------------------------------
   // helper decode and policy mirror
   // ------------------------------------------------------------------
   logic policy_ff;   // copy of the request-policy bit, same timing as the core
   wire  rd_status = reg_req.rd && (reg_req.addr == FSR_OFS_STATUS);
   wire  rd_prot   = reg_req.rd && (reg_req.addr == FSR_OFS_PROTECT);
   wire  unmapped  = (reg_req.addr != FSR_OFS_OC_CTRL) && (reg_req.addr != FSR_OFS_PROTECT) && !rd_status;
   // mirror updates on the write edge so play checks see the new policy next cycle
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         policy_ff <= 1'b0;
      end else if (reg_req.wr && (reg_req.addr == FSR_OFS_OC_CTRL)) begin
         policy_ff <= reg_req.wdata[FSR_POS_ALLOW_REQ];
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // ------------------------------------------------------------------
   // properties
   // ------------------------------------------------------------------
   property p_excl;    play_req |-> (play_accept ^ play_reject); endproperty
   property p_idle;    !play_req |-> !(play_accept || play_reject); endproperty
   property p_accept;  play_req && policy_ff |-> play_accept; endproperty
   // a read-clear may release protection one cycle late, so skip that cycle
   property p_block;   play_req && !policy_ff && protect_shutdown && !$past(reg_req.rd) |-> play_reject; endproperty
   property p_hold;    !reg_req.rd |=> $stable(reg_rdata); endproperty
   property p_prot;    rd_prot |=> (reg_rdata & ~FSR_MSK_PROTECT) == 16'h0000; endproperty
   property p_status;  rd_status |=> (reg_rdata & ~FSR_MSK_STATUS) == 16'h0000; endproperty
   property p_unmap;   reg_req.rd && unmapped |=> reg_rdata == 16'h0000; endproperty
   a_excl:   assert property (p_excl)   else $error("play answer not exclusive");
   a_idle:   assert property (p_idle)   else $error("play answer without request");
   a_accept: assert property (p_accept) else $error("play refused with policy set");
   a_block:  assert property (p_block)  else $error("play taken while protected");
   a_hold:   assert property (p_hold)   else $error("read data moved without read");
   a_prot:   assert property (p_prot)   else $error("protect reserved bits set");
   a_status: assert property (p_status) else $error("status reserved bits set");
   a_unmap:  assert property (p_unmap)  else $error("unmapped read not zero");
   c_accept: cover property (play_req && play_accept);
   c_reject: cover property (play_req && play_reject);
   c_prot:   cover property ($rose(protect_shutdown));
endmodule : fsr_core_chk
bind fsr_core fsr_core_chk u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
   .analog_in(analog_in), .haptic_active(haptic_active), .pump_start_timeout(pump_start_timeout),
   .other_events(other_events), .play_req(play_req), .play_accept(play_accept), .play_reject(play_reject),
   .protect_shutdown(protect_shutdown));

// ---- tb.sv ----
// self-checking bench for the fault supervision core
`timescale 1ns/10ps
module tb;
   import fsr_pkg::*;
   logic        core_clk, sys_rst, hap, cto, preq, acc, rej, shut, rd_tk;
   fsr_req_t    req;        // register port request
   fsr_analog_t an;         // analog condition stimulus
   logic [15:0] rdata, r;   // read data, random word
   logic [4:0]  oev;        // foreign event pulses
   logic [15:0] qr[$];      // expected read data
   logic [2:0]  qp[$];      // expected {accept, reject, shutdown}
   int          n_mismatch, n_tests, cyc;
   fsr_core dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_req(req), .reg_rdata(rdata), .analog_in(an),
      .haptic_active(hap), .pump_start_timeout(cto), .other_events(oev), .play_req(preq), .play_accept(acc),
      .play_reject(rej), .protect_shutdown(shut));
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // ------------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------------
   // compare of one read word against the oldest noted value
   task automatic chk_rd(logic [15:0] exp, logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR rdata expected %h seen %h", exp, got);
      end
   endtask : chk_rd
   // compare of {accept, reject, shutdown} while a playback request stands
   task automatic chk_play(logic [2:0] exp, logic [2:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR play expected %b seen %b", exp, got);
      end
   endtask : chk_play
   task automatic idle(int n);
      repeat (n) @(negedge core_clk);
   endtask : idle
   // one register access; for a read d is the expected word
   task automatic acc_reg(logic w, logic [7:0] a, logic [15:0] d);
      @(negedge core_clk);
      req = '{wr: w, rd: !w, addr: a, wdata: d};
      if (!w) qr.push_back(d);
      @(negedge core_clk);
      req = '0;
   endtask : acc_reg
   task automatic play(logic [2:0] e);
      @(negedge core_clk);
      qp.push_back(e);
      preq = 1'b1;
      @(negedge core_clk);
      preq = 1'b0;
   endtask : play
   // slow pulses so the two-flop synchroniser never misses an edge
   task automatic pulse(int n, logic on);
      repeat (n) begin
         if (on) an.boost_on_cycle = 1'b1; else an.current_limit_pulse = 1'b1;
         idle(2);
         an = an & 7'h1F;
         idle(2);
      end
   endtask : pulse
   task automatic bias_fail;
      an.bias_good = 1'b0;
      idle(4);
      an.bias_good = 1'b1;
      idle(4);
   endtask : bias_fail
   task automatic tally_and_finish;
      // a noted result that never showed up counts as a mismatch
      if (qr.size() != 0 || qp.size() != 0) n_mismatch++;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   // ------------------------------------------------------------------
   // result watchers and hang guard
   // ------------------------------------------------------------------
   always @(posedge core_clk) begin
      rd_tk <= req.rd;
      cyc <= cyc + 1;
      if (preq) chk_play(qp.pop_front(), {acc, rej, shut});
      if (cyc == 10000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   always @(negedge core_clk) if (rd_tk) chk_rd(qr.pop_front(), rdata);
   initial begin
      void'($urandom(70639));
      // idle port levels, reset held
      req = '0;
      an = FSR_RST_ANALOG;
      {hap, cto, preq, rd_tk} = 4'h0;
      oev = 5'h00;
      sys_rst = 1'b1;
      repeat (3) @(negedge core_clk);
      sys_rst = 1'b0;
      acc_reg(0, 8'h04, 16'h0001); acc_reg(0, 8'h05, 16'h001F);
      acc_reg(0, 8'h06, 16'h0000); acc_reg(0, 8'h07, 16'h0000);
      r = 16'($urandom);
      acc_reg(1, 8'h05, r); acc_reg(0, 8'h05, r & 16'h001F);
      acc_reg(1, 8'h05, 16'h001D);
      bias_fail(); play(3'h2); acc_reg(0, 8'h06, 16'h0002);
      acc_reg(1, 8'h05, 16'h001F);
      oev = r[4:0]; cto = 1'b1; idle(1); oev = '0; cto = 1'b0;
      play(3'h2); acc_reg(0, 8'h06, {1'h0, r[4:0], 4'h0, 6'h20});
      bias_fail(); play(3'h3); acc_reg(0, 8'h06, 16'h0002); acc_reg(0, 8'h06, 16'h0000);
      play(3'h4);
      acc_reg(1, 8'h04, 16'h4001); bias_fail(); play(3'h5); acc_reg(0, 8'h06, 16'h0002);
      hap = 1'b1; an.enable_pin_active_low = 1'b1; idle(5); acc_reg(0, 8'h06, 16'h0001);
      hap = 1'b0; an.enable_pin_active_low = 1'b0; idle(4); an.enable_pin_active_low = 1'b1; idle(5);
      acc_reg(0, 8'h06, 16'h0000); an.enable_pin_active_low = 1'b0;
      acc_reg(1, 8'h04, 16'h0000); pulse(128, 0); idle(4); acc_reg(0, 8'h06, 16'h0040);
      pulse(127, 0); pulse(2, 1); pulse(1, 0); idle(4); acc_reg(0, 8'h06, 16'h0000);
      sys_rst = 1'b1; idle(3); sys_rst = 1'b0;
      acc_reg(0, 8'h04, 16'h0001); acc_reg(1, 8'h04, 16'h0000);
      pulse(512, 0); idle(4); play(3'h3); acc_reg(0, 8'h06, 16'h00C0);
      acc_reg(1, 8'h04, 16'h001C); pulse(512, 0); idle(4); play(3'h4); acc_reg(0, 8'h06, 16'h0040);
      // 256 pulses per warning, 64 clean cycles per reset: a run of 63 must not restart the count
      acc_reg(1, 8'h04, 16'h007D); pulse(255, 0); pulse(63, 1); pulse(1, 0); idle(4);
      acc_reg(0, 8'h06, 16'h0040);
      idle(4);
      tally_and_finish();
   end
endmodule : tb
